// file: pin_select_defs.svh
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

// Register byte offsets
`define OFF_FAULT_SEL_7_8    8'h00
`define OFF_MAP_32_33        8'h04
`define OFF_MAP_34_35        8'h08
`define OFF_MAP_36_37        8'h0C

// Field positions
`define FAULT_SEVEN_LSB      0
`define FAULT_EIGHT_LSB      8
`define MAP_LOW_LSB          0
`define MAP_HIGH_LSB         8

// Implemented-bit masks
`define FAULT_SEL_MASK       16'hFFFF
`define MAP_MASK             16'h3F3F

// Reset values
`define FAULT_SEL_RESET      8'h00
`define MAP_FIELD_RESET      6'h00

// Highest remappable pin a fault selector may name
`define FAULT_PIN_MAX        8'hB5

// AXI responses
`define RESP_OKAY            2'h0
`define RESP_DECERR          2'h3

`endif

// file: pin_select_pkg.sv
`default_nettype none
package pin_select_pkg;
  typedef logic [5:0]  function_code_t;
  typedef logic [7:0]  pin_choice_t;
  typedef logic [15:0] reg_word_t;
endpackage
`default_nettype wire

// file: reg_access_if.sv
`default_nettype none
interface reg_access_if #(parameter int ADDR_W = 8);
  logic                       wr_req;
  logic [ADDR_W-1:0]          wr_addr;
  logic [31:0]                wr_data;
  logic [3:0]                 wr_strb;
  logic                       wr_hit;
  logic                       rd_req;
  logic [ADDR_W-1:0]          rd_addr;
  pin_select_pkg::reg_word_t  rd_data;
  logic                       rd_hit;

  modport port (output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                input wr_hit, rd_data, rd_hit);
  modport regs (input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface
`default_nettype wire

// file: axil_reg_port.sv
`include "pin_select_defs.svh"
`default_nettype none
module axil_reg_port #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // Write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Register side
  reg_access_if.port             ra
);
  logic              aw_full;
  logic              w_full;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  // Handshakes and next state
  wire take_aw       = s_axi_awvalid & s_axi_awready;
  wire take_w        = s_axi_wvalid & s_axi_wready;
  wire take_ar       = s_axi_arvalid & s_axi_arready;
  wire do_write      = aw_full & w_full & ~s_axi_bvalid;
  wire next_aw_full  = (aw_full | take_aw) & ~do_write;
  wire next_w_full   = (w_full | take_w) & ~do_write;
  wire next_bvalid   = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire next_rvalid   = take_ar | (s_axi_rvalid & ~s_axi_rready);

  // Requests toward the register file
  assign ra.wr_req  = do_write;
  assign ra.wr_addr = aw_addr_q;
  assign ra.wr_data = w_data_q;
  assign ra.wr_strb = w_strb_q;
  assign ra.rd_req  = take_ar;
  assign ra.rd_addr = s_axi_araddr;

  // Write address and data holding
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      if (take_aw) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (take_w) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // Ready flags and write response
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready  <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= ra.wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end
    end
  end

  // Read answer, one cycle after the address
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (take_ar) begin
        s_axi_rdata <= {16'h0000, ra.rd_data};
        s_axi_rresp <= ra.rd_hit ? `RESP_OKAY : `RESP_DECERR;
      end
    end
  end
endmodule // axil_reg_port
`default_nettype wire

// file: pin_select_map.sv
// Behaviour
// - Map word one holds a six-bit function choice for pin 33 at bits 13-8 and for pin 32 at bits 5-0.
// - Map word two routes the function in bits 13-8 to pin 35 and the one in bits 5-0 to pin 34.
// - Map word three routes the function in bits 13-8 to pin 37 and the one in bits 5-0 to pin 36.
// - Bits 15-14 and 7-6 of every map word are not stored and always read as zero.
// - An eight-bit fault selector value n ties its fault input to remappable pin n up to 181, zero ties it low.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`include "pin_select_defs.svh"
`default_nettype none
module pin_select_map #(
  parameter int ADDR_W   = 8,
  parameter int NUM_PINS = 182
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        arst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // Remappable pin levels, index is the pin number
  input  wire logic [NUM_PINS-1:0]         remappable_pin_n,
  // Per-pin function-select vectors
  output pin_select_pkg::function_code_t   pin32_function_choice,
  output pin_select_pkg::function_code_t   pin33_function_choice,
  output pin_select_pkg::function_code_t   pin34_function_choice,
  output pin_select_pkg::function_code_t   pin35_function_choice,
  output pin_select_pkg::function_code_t   pin36_function_choice,
  output pin_select_pkg::function_code_t   pin37_function_choice,
  // PWM fault inputs
  output logic                             pwm_fault_input_seven,
  output logic                             pwm_fault_input_eight
);

  pin_select_pkg::pin_choice_t fault_seven_pin_choice;
  pin_select_pkg::pin_choice_t fault_eight_pin_choice;

  // Request and answer wires between front end and registers
  reg_access_if #(.ADDR_W(ADDR_W)) ra ();

  // Bus slave front end
  axil_reg_port #(.ADDR_W(ADDR_W)) u_port (
    .sys_clk       (sys_clk),
    .arst_n        (arst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ra            (ra)
  );

  // Byte-lane merge, unimplemented bits forced to zero
  // Lanes 2 and 3 have no storage behind them
  function automatic pin_select_pkg::reg_word_t merge_word(
    input pin_select_pkg::reg_word_t old_word,
    input logic [31:0]               data,
    input logic [3:0]                strb,
    input pin_select_pkg::reg_word_t mask
  );
    pin_select_pkg::reg_word_t w;
    w = old_word;
    if (strb[0]) begin
      w[7:0] = data[7:0];
    end
    if (strb[1]) begin
      w[15:8] = data[15:8];
    end
    return w & mask;
  endfunction

  // Fault source pick: zero or out of range ties low
  // Out-of-range values would otherwise index past the pin vector
  function automatic logic fault_source(
    input pin_select_pkg::pin_choice_t sel,
    input logic [NUM_PINS-1:0]         pins
  );
    logic hit;
    logic in_range;
    hit      = 1'b0;
    in_range = sel <= `FAULT_PIN_MAX && int'(sel) < NUM_PINS; // Index stays inside the pins
    if (sel != 8'h00 && in_range) begin
      hit = pins[sel];
    end
    return hit;
  endfunction

  // Word-aligned address of each request
  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'b00};
  endfunction

  // Low address bits dropped, so any byte address hits its word
  // Write decode
  wire [ADDR_W-1:0] wa       = word_addr(ra.wr_addr);
  wire              w_fault  = wa == ADDR_W'(`OFF_FAULT_SEL_7_8);
  wire              w_map1   = wa == ADDR_W'(`OFF_MAP_32_33);
  wire              w_map2   = wa == ADDR_W'(`OFF_MAP_34_35);
  wire              w_map3   = wa == ADDR_W'(`OFF_MAP_36_37);
  assign ra.wr_hit = w_fault | w_map1 | w_map2 | w_map3;

  // Present words as software sees them
  wire pin_select_pkg::reg_word_t fault_word =
    {fault_eight_pin_choice, fault_seven_pin_choice};
  wire pin_select_pkg::reg_word_t map1_word =
    {2'b00, pin33_function_choice, 2'b00, pin32_function_choice};
  wire pin_select_pkg::reg_word_t map2_word =
    {2'b00, pin35_function_choice, 2'b00, pin34_function_choice};
  wire pin_select_pkg::reg_word_t map3_word =
    {2'b00, pin37_function_choice, 2'b00, pin36_function_choice};

  // Next words after a write
  wire pin_select_pkg::reg_word_t next_fault_word =
    merge_word(fault_word, ra.wr_data, ra.wr_strb, `FAULT_SEL_MASK);
  wire pin_select_pkg::reg_word_t next_map1_word =
    merge_word(map1_word, ra.wr_data, ra.wr_strb, `MAP_MASK);
  wire pin_select_pkg::reg_word_t next_map2_word =
    merge_word(map2_word, ra.wr_data, ra.wr_strb, `MAP_MASK);
  wire pin_select_pkg::reg_word_t next_map3_word =
    merge_word(map3_word, ra.wr_data, ra.wr_strb, `MAP_MASK);

  // Unmapped words read as zero with a decode error
  // Read decode and data select
  wire [ADDR_W-1:0] rda     = word_addr(ra.rd_addr);
  wire              r_fault = rda == ADDR_W'(`OFF_FAULT_SEL_7_8);
  wire              r_map1  = rda == ADDR_W'(`OFF_MAP_32_33);
  wire              r_map2  = rda == ADDR_W'(`OFF_MAP_34_35);
  wire              r_map3  = rda == ADDR_W'(`OFF_MAP_36_37);
  assign ra.rd_hit  = r_fault | r_map1 | r_map2 | r_map3;
  assign ra.rd_data = r_fault ? fault_word :
                      r_map1  ? map1_word  :
                      r_map2  ? map2_word  :
                      r_map3  ? map3_word  : 16'h0000;

  // All eight bits stored, so out-of-range values read back as written
  // Fault input selectors
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_seven_pin_choice <= `FAULT_SEL_RESET;
      fault_eight_pin_choice <= `FAULT_SEL_RESET;
    end else if (ra.wr_req && w_fault) begin
      fault_seven_pin_choice <= next_fault_word[`FAULT_SEVEN_LSB +: 8];
      fault_eight_pin_choice <= next_fault_word[`FAULT_EIGHT_LSB +: 8];
    end
  end

  // Unimplemented bits are masked off before these registers
  // Pins 32 and 33
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin32_function_choice <= `MAP_FIELD_RESET;
      pin33_function_choice <= `MAP_FIELD_RESET;
    end else if (ra.wr_req && w_map1) begin
      pin32_function_choice <= next_map1_word[`MAP_LOW_LSB +: 6];
      pin33_function_choice <= next_map1_word[`MAP_HIGH_LSB +: 6];
    end
  end

  // Pins 34 and 35
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin34_function_choice <= `MAP_FIELD_RESET;
      pin35_function_choice <= `MAP_FIELD_RESET;
    end else if (ra.wr_req && w_map2) begin
      pin34_function_choice <= next_map2_word[`MAP_LOW_LSB +: 6];
      pin35_function_choice <= next_map2_word[`MAP_HIGH_LSB +: 6];
    end
  end

  // Pins 36 and 37
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin36_function_choice <= `MAP_FIELD_RESET;
      pin37_function_choice <= `MAP_FIELD_RESET;
    end else if (ra.wr_req && w_map3) begin
      pin36_function_choice <= next_map3_word[`MAP_LOW_LSB +: 6];
      pin37_function_choice <= next_map3_word[`MAP_HIGH_LSB +: 6];
    end
  end

  // The extra flop keeps these outputs straight from a register
  // Fault inputs follow their chosen pin, one cycle later
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_fault_input_seven <= 1'b0;
      pwm_fault_input_eight <= 1'b0;
    end else begin
      pwm_fault_input_seven <= fault_source(fault_seven_pin_choice, remappable_pin_n);
      pwm_fault_input_eight <= fault_source(fault_eight_pin_choice, remappable_pin_n);
    end
  end

endmodule // pin_select_map
`default_nettype wire

// file: pin_select_map_monitor.sv
`include "pin_select_defs.svh"
`default_nettype none
module pin_select_map_monitor #(
  parameter int NUM_PINS = 182
) (
  // Clock, reset and bus
  input wire logic                           sys_clk,
  input wire logic                           arst_n,
  input wire logic [7:0]                     s_axi_awaddr,
  input wire logic                           s_axi_awvalid,
  input wire logic                           s_axi_awready,
  input wire logic [31:0]                    s_axi_wdata,
  input wire logic [3:0]                     s_axi_wstrb,
  input wire logic                           s_axi_wvalid,
  input wire logic                           s_axi_wready,
  input wire logic [1:0]                     s_axi_bresp,
  input wire logic                           s_axi_bvalid,
  input wire logic                           s_axi_bready,
  input wire logic [7:0]                     s_axi_araddr,
  input wire logic                           s_axi_arvalid,
  input wire logic                           s_axi_arready,
  input wire logic [31:0]                    s_axi_rdata,
  input wire logic                           s_axi_rvalid,
  // Pins and selectors
  input wire logic [NUM_PINS-1:0]            remappable_pin_n,
  input wire pin_select_pkg::function_code_t pin32_function_choice,
  input wire pin_select_pkg::function_code_t pin33_function_choice,
  input wire pin_select_pkg::function_code_t pin34_function_choice,
  input wire pin_select_pkg::function_code_t pin35_function_choice,
  input wire pin_select_pkg::function_code_t pin36_function_choice,
  input wire pin_select_pkg::function_code_t pin37_function_choice,
  input wire logic                           pwm_fault_input_seven,
  input wire logic                           pwm_fault_input_eight
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  aw_q;
  logic [7:0]  ar_q;
  logic [31:0] w_q;
  logic [3:0]  s_q;
  logic [15:0] fsel;
  logic        exp7;
  logic        exp8;
  // Fault levels expected from the shadowed selector word
  assign exp7 = (fsel[7:0] != 8'h00 && int'(fsel[7:0]) < NUM_PINS) ? remappable_pin_n[fsel[7:0]] : 1'b0;
  assign exp8 = (fsel[15:8] != 8'h00 && int'(fsel[15:8]) < NUM_PINS) ? remappable_pin_n[fsel[15:8]] : 1'b0;
  // Capture handshakes; shadow the selector word once the write is answered
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
      w_q  <= 32'h0;
      s_q  <= 4'h0;
      fsel <= 16'h0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata;
      if (s_axi_wvalid && s_axi_wready) s_q <= s_axi_wstrb;
      if (s_axi_bvalid && s_axi_bready && s_axi_bresp == `RESP_OKAY && aw_q[7:2] == 6'h00) begin
        fsel <= {s_q[1] ? w_q[15:8] : fsel[15:8], s_q[0] ? w_q[7:0] : fsel[7:0]};
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_reset_clear;
    $rose(arst_n) |-> {pin37_function_choice, pin36_function_choice, pin35_function_choice, pin34_function_choice,
      pin33_function_choice, pin32_function_choice, pwm_fault_input_seven, pwm_fault_input_eight} == 38'h0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("selectors not clear after reset");
  property p_unimpl_zero;
    s_axi_rvalid && ar_q[7:2] inside {6'h01, 6'h02, 6'h03} |-> s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[7:6] == 2'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unused map bits read nonzero");
  property p_map_one;
    $rose(s_axi_rvalid) && ar_q[7:2] == 6'h01 |->
      s_axi_rdata[13:0] == {$past(pin33_function_choice), 2'b00, $past(pin32_function_choice)};
  endproperty
  a_map_one: assert property (p_map_one) else $error("pins 32 33 differ from word one");
  property p_map_two;
    $rose(s_axi_rvalid) && ar_q[7:2] == 6'h02 |->
      s_axi_rdata[13:0] == {$past(pin35_function_choice), 2'b00, $past(pin34_function_choice)};
  endproperty
  a_map_two: assert property (p_map_two) else $error("pins 34 35 differ from word two");
  property p_map_three;
    $rose(s_axi_rvalid) && ar_q[7:2] == 6'h03 |->
      s_axi_rdata[13:0] == {$past(pin37_function_choice), 2'b00, $past(pin36_function_choice)};
  endproperty
  a_map_three: assert property (p_map_three) else $error("pins 36 37 differ from word three");
  property p_fault_seven;
    !$past(s_axi_bvalid) |-> pwm_fault_input_seven == $past(exp7);
  endproperty
  a_fault_seven: assert property (p_fault_seven) else $error("fault seven not from chosen pin");
  property p_fault_eight;
    !$past(s_axi_bvalid) |-> pwm_fault_input_eight == $past(exp8);
  endproperty
  a_fault_eight: assert property (p_fault_eight) else $error("fault eight not from chosen pin");
  // Main scenarios reached
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && ar_q[7:2] == 6'h03);
  c_fault: cover property (pwm_fault_input_eight && fsel[15:8] == 8'hB5);
endmodule // pin_select_map_monitor
bind pin_select_map pin_select_map_monitor #(.NUM_PINS(NUM_PINS)) mon (.sys_clk, .arst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .remappable_pin_n, .pin32_function_choice, .pin33_function_choice, .pin34_function_choice,
  .pin35_function_choice, .pin36_function_choice, .pin37_function_choice, .pwm_fault_input_seven,
  .pwm_fault_input_eight);
`default_nettype wire

// file: tb.sv
`include "pin_select_defs.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           sys_clk, arst_n;
  logic [7:0]                     s_axi_awaddr, s_axi_araddr;
  logic [31:0]                    s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]                     s_axi_wstrb;
  logic [1:0]                     s_axi_bresp, s_axi_rresp, rsp;
  logic                           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic                           s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [181:0]                   remappable_pin_n, pat;
  pin_select_pkg::function_code_t pin32_function_choice, pin33_function_choice, pin34_function_choice;
  pin_select_pkg::function_code_t pin35_function_choice, pin36_function_choice, pin37_function_choice;
  logic                           pwm_fault_input_seven, pwm_fault_input_eight;
  logic [35:0]                    pins_all;
  logic [15:0]                    v;
  logic [7:0]                     sels [5];
  int                             n_errors, cmp_count, cycles;
  assign pins_all = {pin37_function_choice, pin36_function_choice, pin35_function_choice,
                     pin34_function_choice, pin33_function_choice, pin32_function_choice};
  pin_select_map dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .remappable_pin_n, .pin32_function_choice, .pin33_function_choice, .pin34_function_choice,
    .pin35_function_choice, .pin36_function_choice, .pin37_function_choice, .pwm_fault_input_seven,
    .pwm_fault_input_eight);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [71:0] got, input logic [71:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write cycle: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read cycle
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic fexp(input logic [7:0] s, input logic [181:0] p);
    return (s != 8'h00 && s <= `FAULT_PIN_MAX) ? p[s] : 1'b0;
  endfunction
  // Main sequence
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    remappable_pin_n = '1;
    sels = '{8'h00, 8'h01, 8'h5A, 8'hB5, 8'hB6};
    n_errors = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_reg(8'(4 * i));
      check("reset word", {rsp, rd}, 34'h0);
    end
    check("reset outputs", {pins_all, pwm_fault_input_seven, pwm_fault_input_eight}, 38'h0);
    for (int i = 1; i < 4; i++) begin
      v = 16'hFFFF ^ 16'(i * 16'h0902);
      wr(8'(4 * i), {16'hFFFF, v}, 4'hF);
      rd_reg(8'(4 * i));
      check("map word", {rsp, rd}, {`RESP_OKAY, 16'h0, v & `MAP_MASK});
      check("map pins", pins_all[12 * i - 1 -: 12], {v[13:8], v[5:0]});
      wr(8'(4 * i), 32'hFFFF_1500, 4'h2);
      check("high byte only", pins_all[12 * i - 1 -: 12], {6'h15, v[5:0]});
    end
    wr(8'h10, 32'h0000_FFFF, 4'hF);
    check("unmapped write", rsp, `RESP_DECERR);
    rd_reg(8'h10);
    check("unmapped read", {rsp, rd}, {`RESP_DECERR, 32'h0});
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {16'h0, sels[4 - i], sels[i]}, 4'hF);
      rd_reg(8'h00);
      check("fault word", rd, {16'h0, sels[4 - i], sels[i]});
      for (int k = 0; k < 2; k++) begin
        pat = k ? ~{91{2'b01}} : {91{2'b01}};
        remappable_pin_n <= pat;
        repeat (2) @(posedge sys_clk);
        check("fault inputs", {pwm_fault_input_seven, pwm_fault_input_eight},
              {fexp(sels[i], pat), fexp(sels[4 - i], pat)});
      end
    end
    wr(8'h00, 32'hFFFF_FF22, 4'h1);
    rd_reg(8'h00);
    check("low byte only", rd, 32'h0000_0022);
    arst_n <= 1'b0;
    @(posedge sys_clk);
    arst_n <= 1'b1;
    rd_reg(8'h0C);
    check("second reset", {pins_all, pwm_fault_input_seven, pwm_fault_input_eight, rd}, 70'h0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
